//--- dram_params.svh
// Register offsets, field positions and reset timing counts for the loop and leveling block
`ifndef DRAM_PARAMS_SVH
`define DRAM_PARAMS_SVH
`define OFS_CTRL 6'h00
`define OFS_T_MODE_SET 6'h04
`define OFS_T_MODE_CYCLE 6'h08
`define OFS_T_EXIT 6'h0C
`define OFS_T_EXIT_FAST 6'h10
`define OFS_T_EXIT_ABORT 6'h14
`define OFS_T_LOCK 6'h18
`define OFS_T_CALIB 6'h1C
`define OFS_STATUS 6'h20
`define OFS_VIOL 6'h24
`define CTRL_ABORT_EN 0
`define CTRL_PER_DEVICE 1
`define MR1_LOOP_CONTROL 0
`define MR1_LEVELING 7
`define MR1_OUT_DISABLE 12
`define MR0_LOOP_RESET 8
`define RST_T_MODE_SET 16'h0018
`define RST_T_MODE_CYCLE 16'h0008
`define RST_T_EXIT 16'h0100
`define RST_T_EXIT_FAST 16'h0080
`define RST_T_EXIT_ABORT 16'h0090
`define RST_T_LOCK_MIN 16'h0255
`define RST_T_LOCK 16'h0400
`define RST_T_CALIB 16'h0200
`define RST_CTRL 2'h0
`define VIOL_MODE_SET 0
`define VIOL_MODE_CYCLE 1
`define VIOL_EXIT 2
`define VIOL_LOCK 3
`define VIOL_CALIB 4
`define VIOL_LEVEL 5
`define VIOL_REFRESH 6
`define VIOL_CKE 7
`endif

//--- dram_pkg.sv
// Types shared by the loop and leveling block
package dram_pkg;
  typedef enum logic [3:0] {
    CMD_DESELECT, CMD_MODE_SET, CMD_REFRESH, CMD_SR_ENTRY, CMD_SR_EXIT,
    CMD_LONG_CALIB, CMD_SHORT_CALIB, CMD_ACTIVATE, CMD_PRECHARGE,
    CMD_READ, CMD_WRITE, CMD_PD_ENTRY
  } cmd_kind_t;
  typedef struct packed {
    cmd_kind_t kind;
    logic [2:0] mr_sel;
    logic [17:0] mr_data;
  } dram_cmd_t;
  typedef struct packed {
    logic read;
    logic write;
    logic [5:0] address;
    logic [31:0] writedata;
  } avm_req_t;
  typedef enum logic [2:0] {
    TMR_MODE_SET, TMR_MODE_CYCLE, TMR_EXIT, TMR_EXIT_FAST, TMR_LOCK, TMR_CALIB
  } tmr_idx_t;
  typedef enum logic {ST_ACTIVE, ST_SELF_REFRESH} sr_state_t;
endpackage

//--- level_sampler.sv
// Per-lane write leveling sampler: clock level caught on each rising strobe
`timescale 1ns/1ps
module level_sampler #(
  parameter int LANES = 2,
  parameter int LANE_W = 8
) (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic enable,
  input wire logic out_disable,
  input wire logic ck_level,
  input wire logic [LANES-1:0] strobe,
  output logic [LANES*LANE_W-1:0] fb_data,
  output logic [LANES*LANE_W-1:0] fb_oe_n
);
  genvar g;
  generate
    for (g = 0; g < LANES; g++) begin : lane
      logic prev_r;
      logic prev_nxt;
      logic [LANE_W-1:0] data_r;
      logic [LANE_W-1:0] data_nxt;
      logic [LANE_W-1:0] oe_n_r;
      logic [LANE_W-1:0] oe_n_nxt;
      always_comb begin
        prev_nxt = strobe[g];
        data_nxt = data_r;
        if (enable && strobe[g] && !prev_r) begin
          data_nxt = {LANE_W{ck_level}};
        end
        oe_n_nxt = {LANE_W{!(enable && !out_disable)}};
      end
      always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
          prev_r <= 1'b0;
          data_r <= '0;
          oe_n_r <= '1;
        end else begin
          prev_r <= prev_nxt;
          data_r <= data_nxt;
          oe_n_r <= oe_n_nxt;
        end
      end
      assign fb_data[g*LANE_W +: LANE_W] = data_r;
      assign fb_oe_n[g*LANE_W +: LANE_W] = oe_n_r;
      AST_LANE_SAMPLE: assert property (@(posedge sys_clk) disable iff (!reset_n)
        (enable && strobe[g] && !prev_r) |=> (data_r == {LANE_W{$past(ck_level)}}))
        else $error("lane feedback does not match sampled clock level");
    end
  endgenerate
  AST_FB_DRIVE: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (enable && !out_disable) |=> (fb_oe_n == '0) || !$past(enable))
    else $error("feedback not driven while leveling");
endmodule

//--- dram_dll_wl.sv
// Loop switching, self refresh exit timing and write leveling logic of the memory device
//
// Contract
// - After fast exit delay: calibration and limited mode writes only; rest wait full.
// - With abort enabled, exit skips refresh count; commands allowed after abort delay.
// - Loop lock time spans 597 to 1024 clock cycles.
// - Leveling samples clock level on rising strobe, returns it on data lines.
// - Every data bit carries feedback; each byte lane follows its own strobe.
// - Device terminates strobe during leveling; controller terminates data lines (the controller model terminates nothing and holds termination_control_pin low).
// - Leveling bit of mode register one enters leveling when high, leaves when low.
//
// Register access over Avalon-MM and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
`include "dram_params.svh"
module dram_dll_wl #(
  parameter int LANES = 2,
  parameter int LANE_W = 8,
  parameter logic [15:0] LOCK_DEFAULT = `RST_T_LOCK
) (
  input wire logic sys_clk,
  input wire logic reset_n,
  input dram_pkg::avm_req_t avm_req,
  output logic [31:0] avm_readdata,
  output logic avm_waitrequest,
  input dram_pkg::dram_cmd_t cmd,
  input wire logic cke,
  input wire logic termination_control_pin,
  input wire logic ck_level,
  input wire logic [LANES-1:0] strobe,
  output logic [LANES*LANE_W-1:0] fb_data,
  output logic [LANES*LANE_W-1:0] fb_oe_n,
  output logic strobe_term_on,
  output logic in_self_refresh,
  output logic loop_enabled
);
  import dram_pkg::*;

  localparam int NTMR = 6;
  localparam int NCFG = 7;

  logic [15:0] tmr_r [NTMR];
  logic [15:0] tmr_nxt [NTMR];
  logic [15:0] cfg_r [NCFG];
  logic [15:0] cfg_nxt [NCFG];
  logic [1:0] ctrl_r, ctrl_nxt;
  logic [7:0] viol_r, viol_nxt, viol_hit;
  logic [15:0] refresh_cnt_r, refresh_cnt_nxt;
  logic need_refresh_r, need_refresh_nxt;
  logic loop_en_r, loop_en_nxt;
  logic level_r, level_nxt;
  logic out_dis_r, out_dis_nxt;
  logic term_r, term_nxt;
  sr_state_t state_r, state_nxt;
  logic wait_r, wait_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic is_mode_set, is_mr1, fast_ok, is_calib, full_class, abort_en;
  logic [2:0] cfg_idx;

  always_comb begin
    cfg_idx = avm_req.address[4:2] - 3'd1;
    abort_en = ctrl_r[`CTRL_ABORT_EN];
    is_mode_set = (cmd.kind == CMD_MODE_SET);
    is_mr1 = is_mode_set && (cmd.mr_sel == 3'd1);
    is_calib = (cmd.kind == CMD_LONG_CALIB) || (cmd.kind == CMD_SHORT_CALIB);
    fast_ok = is_mode_set && !ctrl_r[`CTRL_PER_DEVICE] &&
      (cmd.mr_sel == 3'd0 || cmd.mr_sel == 3'd2 || cmd.mr_sel == 3'd3);
    full_class = !is_calib && !is_mode_set && (cmd.kind != CMD_DESELECT);
    for (int i = 0; i < NTMR; i++) begin
      tmr_nxt[i] = (tmr_r[i] != 16'h0000) ? tmr_r[i] - 16'h0001 : 16'h0000;
    end
    state_nxt = state_r;
    refresh_cnt_nxt = refresh_cnt_r;
    need_refresh_nxt = need_refresh_r;
    loop_en_nxt = loop_en_r;
    level_nxt = level_r;
    out_dis_nxt = out_dis_r;
    term_nxt = level_r;
    viol_hit = 8'h00;
    if (state_r == ST_SELF_REFRESH) begin
      if (cmd.kind == CMD_SR_EXIT) begin
        state_nxt = ST_ACTIVE;
        need_refresh_nxt = 1'b1;
        if (abort_en) begin
          tmr_nxt[TMR_EXIT] = cfg_r[4];
          tmr_nxt[TMR_EXIT_FAST] = cfg_r[4];
        end else begin
          tmr_nxt[TMR_EXIT] = cfg_r[2];
          tmr_nxt[TMR_EXIT_FAST] = cfg_r[3];
          refresh_cnt_nxt = refresh_cnt_r + 16'h0001;
        end
      end
    end else begin
      if (cmd.kind != CMD_DESELECT) begin
        viol_hit[`VIOL_MODE_SET] = !is_mode_set && (tmr_r[TMR_MODE_SET] != 16'h0000);
        viol_hit[`VIOL_MODE_CYCLE] = is_mode_set && (tmr_r[TMR_MODE_CYCLE] != 16'h0000);
        viol_hit[`VIOL_EXIT] = (tmr_r[TMR_EXIT] != 16'h0000) &&
          (full_class || !(is_calib || fast_ok) || (tmr_r[TMR_EXIT_FAST] != 16'h0000));
        viol_hit[`VIOL_LOCK] = loop_en_r && (tmr_r[TMR_LOCK] != 16'h0000) &&
          (cmd.kind == CMD_READ || cmd.kind == CMD_WRITE);
        viol_hit[`VIOL_CALIB] = (tmr_r[TMR_CALIB] != 16'h0000);
        viol_hit[`VIOL_LEVEL] = level_r && !is_mr1;
        viol_hit[`VIOL_REFRESH] = (cmd.kind == CMD_SR_ENTRY) && need_refresh_r;
      end
      viol_hit[`VIOL_CKE] = !cke && (cmd.kind != CMD_SR_ENTRY) &&
        ((tmr_r[TMR_MODE_SET] != 16'h0000) || (tmr_r[TMR_LOCK] != 16'h0000) ||
        (tmr_r[TMR_EXIT] != 16'h0000));
      unique case (cmd.kind)
        CMD_MODE_SET: begin
          tmr_nxt[TMR_MODE_SET] = cfg_r[0];
          tmr_nxt[TMR_MODE_CYCLE] = cfg_r[1];
          if (cmd.mr_sel == 3'd1) begin
            loop_en_nxt = cmd.mr_data[`MR1_LOOP_CONTROL];
            level_nxt = cmd.mr_data[`MR1_LEVELING];
            out_dis_nxt = cmd.mr_data[`MR1_OUT_DISABLE];
          end
          if (cmd.mr_sel == 3'd0 && cmd.mr_data[`MR0_LOOP_RESET] && loop_en_r) begin
            tmr_nxt[TMR_LOCK] = cfg_r[5];
          end
        end
        CMD_REFRESH: begin
          refresh_cnt_nxt = refresh_cnt_r + 16'h0001;
          need_refresh_nxt = 1'b0;
        end
        CMD_SR_ENTRY: state_nxt = ST_SELF_REFRESH;
        CMD_LONG_CALIB: tmr_nxt[TMR_CALIB] = cfg_r[6];
        CMD_SHORT_CALIB: tmr_nxt[TMR_CALIB] = {1'b0, cfg_r[6][15:1]};
        default: ;
      endcase
    end
  end

  always_comb begin
    ctrl_nxt = ctrl_r;
    viol_nxt = viol_r | viol_hit;
    for (int i = 0; i < NCFG; i++) begin
      cfg_nxt[i] = cfg_r[i];
    end
    wait_nxt = !((avm_req.read || avm_req.write) && wait_r);
    rdata_nxt = rdata_r;
    if (avm_req.write && !wait_r) begin
      if (avm_req.address == `OFS_CTRL) begin
        ctrl_nxt = avm_req.writedata[1:0];
      end else if (avm_req.address == `OFS_VIOL) begin
        viol_nxt = (viol_r & ~avm_req.writedata[7:0]) | viol_hit;
      end else if (avm_req.address >= `OFS_T_MODE_SET && avm_req.address <= `OFS_T_CALIB &&
          avm_req.address[1:0] == 2'b00) begin
        cfg_nxt[cfg_idx] = avm_req.writedata[15:0];
      end
    end
    if (avm_req.read && wait_r) begin
      if (avm_req.address == `OFS_CTRL) begin
        rdata_nxt = {30'h0, ctrl_r};
      end else if (avm_req.address == `OFS_STATUS) begin
        rdata_nxt = {refresh_cnt_r, 11'h0, need_refresh_r, out_dis_r, level_r, loop_en_r,
          state_r == ST_SELF_REFRESH};
      end else if (avm_req.address == `OFS_VIOL) begin
        rdata_nxt = {24'h0, viol_r};
      end else if (avm_req.address >= `OFS_T_MODE_SET && avm_req.address <= `OFS_T_CALIB &&
          avm_req.address[1:0] == 2'b00) begin
        rdata_nxt = {16'h0, cfg_r[cfg_idx]};
      end else begin
        rdata_nxt = 32'h0000_0000;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      for (int i = 0; i < NTMR; i++) begin
        tmr_r[i] <= 16'h0000;
      end
      cfg_r[0] <= `RST_T_MODE_SET;
      cfg_r[1] <= `RST_T_MODE_CYCLE;
      cfg_r[2] <= `RST_T_EXIT;
      cfg_r[3] <= `RST_T_EXIT_FAST;
      cfg_r[4] <= `RST_T_EXIT_ABORT;
      cfg_r[5] <= LOCK_DEFAULT;
      cfg_r[6] <= `RST_T_CALIB;
      ctrl_r <= `RST_CTRL;
      viol_r <= 8'h00;
      refresh_cnt_r <= 16'h0000;
      need_refresh_r <= 1'b0;
      loop_en_r <= 1'b1;
      level_r <= 1'b0;
      out_dis_r <= 1'b0;
      term_r <= 1'b0;
      state_r <= ST_ACTIVE;
      wait_r <= 1'b1;
      rdata_r <= 32'h0000_0000;
    end else begin
      tmr_r <= tmr_nxt;
      cfg_r <= cfg_nxt;
      ctrl_r <= ctrl_nxt;
      viol_r <= viol_nxt;
      refresh_cnt_r <= refresh_cnt_nxt;
      need_refresh_r <= need_refresh_nxt;
      loop_en_r <= loop_en_nxt;
      level_r <= level_nxt;
      out_dis_r <= out_dis_nxt;
      term_r <= term_nxt;
      state_r <= state_nxt;
      wait_r <= wait_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  level_sampler #(.LANES(LANES), .LANE_W(LANE_W)) sampler (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .enable(level_r),
    .out_disable(out_dis_r),
    .ck_level(ck_level),
    .strobe(strobe),
    .fb_data(fb_data),
    .fb_oe_n(fb_oe_n)
  );

  assign avm_readdata = rdata_r;
  assign avm_waitrequest = wait_r;
  assign strobe_term_on = term_r;
  assign in_self_refresh = (state_r == ST_SELF_REFRESH);
  assign loop_enabled = loop_en_r;

  AST_LEVEL_ENTRY: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (state_r == ST_ACTIVE && is_mr1) |=> (level_r == $past(cmd.mr_data[`MR1_LEVELING])))
    else $error("leveling state does not follow mode register one");
  AST_STROBE_TERM: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (state_r == ST_ACTIVE && is_mr1 && cmd.mr_data[`MR1_LEVELING]) |-> ##2 strobe_term_on)
    else $error("strobe termination not applied in leveling");
  AST_LOCK_LOAD: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (state_r == ST_ACTIVE && is_mode_set && cmd.mr_sel == 3'd0 &&
    cmd.mr_data[`MR0_LOOP_RESET] && loop_en_r) |=> (tmr_r[TMR_LOCK] == cfg_r[5]))
    else $error("lock timer not loaded on loop reset");
  AST_LOCK_RANGE: assert property (@(posedge sys_clk) disable iff (!reset_n)
    $rose(reset_n) |-> (cfg_r[5] >= `RST_T_LOCK_MIN && cfg_r[5] <= `RST_T_LOCK))
    else $error("lock time default outside range");
  AST_ABORT_COUNT: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (state_r == ST_SELF_REFRESH && cmd.kind == CMD_SR_EXIT && abort_en)
    |=> (refresh_cnt_r == $past(refresh_cnt_r)) && (tmr_r[TMR_EXIT] == cfg_r[4]))
    else $error("abort exit advanced the refresh counter or used wrong delay");
  AST_EXIT_FULL: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (state_r == ST_ACTIVE && full_class && tmr_r[TMR_EXIT] != 16'h0000)
    |=> viol_r[`VIOL_EXIT])
    else $error("early command after exit not flagged");
  AST_TIMER_DOWN: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (tmr_r[TMR_MODE_SET] > 16'h0001 && !is_mode_set)
    |=> (tmr_r[TMR_MODE_SET] == $past(tmr_r[TMR_MODE_SET]) - 16'h0001))
    else $error("mode-set timer failed to count down");
  AST_BUS_ANSWER: assert property (@(posedge sys_clk) disable iff (!reset_n)
    ((avm_req.read || avm_req.write) && avm_waitrequest) |=> !avm_waitrequest ##1 avm_waitrequest)
    else $error("bus answer not one cycle after request");
endmodule

//--- mem_ctrl_model.sv
// Memory controller side: forwards commands, clock enable and strobe requests, holds termination low
`timescale 1ns/1ps
module mem_ctrl_model #(
  parameter int LANES = 2
) (
  input wire logic sys_clk,
  input wire logic reset_n,
  input dram_pkg::dram_cmd_t cmd_req,
  input wire logic [LANES-1:0] strobe_req,
  input wire logic cke_req,
  output dram_pkg::dram_cmd_t cmd,
  output logic cke,
  output logic termination_control_pin,
  output logic [LANES-1:0] strobe
);
  import dram_pkg::*;
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      cmd <= '{kind: CMD_DESELECT, mr_sel: 3'h0, mr_data: 18'h0};
      cke <= 1'b0;
      termination_control_pin <= 1'b0;
      strobe <= '0;
    end else begin
      cmd <= cmd_req;
      cke <= cke_req;
      termination_control_pin <= 1'b0;
      strobe <= strobe_req;
    end
  end
endmodule

//--- dram_dll_wl_test.sv
// Self-checking bench for the loop switching and write leveling block
`timescale 1ns/1ps
`include "dram_params.svh"
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin err_count++; \
  $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e); end end
module dram_dll_wl_test;
  import dram_pkg::*;
  logic sys_clk = 1'b0;
  logic reset_n;
  avm_req_t avm_req = '0;
  logic [31:0] avm_readdata;
  logic avm_waitrequest;
  dram_cmd_t cmd_req = '{kind: CMD_DESELECT, mr_sel: 3'h0, mr_data: 18'h0};
  dram_cmd_t cmd;
  logic cke;
  logic cke_req = 1'b1;
  logic termination_control_pin;
  logic ck_level = 1'b0;
  logic [1:0] strobe_req = 2'h0;
  logic [1:0] strobe;
  logic [15:0] fb_data;
  logic [15:0] fb_oe_n;
  logic [15:0] exp_fb = 16'h0;
  logic strobe_term_on;
  logic in_self_refresh;
  logic loop_enabled;
  int err_count = 0;
  int compares = 0;
  int cycles = 0;
  int refcnt = 0;
  logic [31:0] rng = 32'h7C338309;
  logic [31:0] rd;
  logic [31:0] exp_viol = 32'h0;
  logic [15:0] dflt [8] = '{16'h0000, 16'h0018, 16'h0008, 16'h0100, 16'h0080, 16'h0090,
                            16'h0255, 16'h0200};

  mem_ctrl_model #(.LANES(2)) mem_ctrl_model_inst (.sys_clk(sys_clk), .reset_n(reset_n),
    .cmd_req(cmd_req), .strobe_req(strobe_req), .cke_req(cke_req), .cmd(cmd), .cke(cke),
    .termination_control_pin(termination_control_pin), .strobe(strobe));

  dram_dll_wl #(.LANES(2), .LANE_W(8), .LOCK_DEFAULT(16'h0255)) dram_dll_wl_inst (
    .sys_clk(sys_clk), .reset_n(reset_n), .avm_req(avm_req), .avm_readdata(avm_readdata),
    .avm_waitrequest(avm_waitrequest), .cmd(cmd), .cke(cke),
    .termination_control_pin(termination_control_pin), .ck_level(ck_level), .strobe(strobe),
    .fb_data(fb_data), .fb_oe_n(fb_oe_n), .strobe_term_on(strobe_term_on),
    .in_self_refresh(in_self_refresh), .loop_enabled(loop_enabled));

  initial begin
    forever #20 sys_clk = ~sys_clk;
  end

  function automatic logic [31:0] xs(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction

  task automatic stop_test();
    $display("Comparisons %0d, mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge sys_clk);
  endtask

  // Holds the request until waitrequest is sampled low, then releases and lets an edge pass
  task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] d);
    avm_req <= '{read: !wr, write: wr, address: a, writedata: d};
    do @(posedge sys_clk); while (avm_waitrequest !== 1'b0);
    rd = avm_readdata;
    avm_req <= '0;
    @(posedge sys_clk);
  endtask

  task automatic send(input cmd_kind_t k, input logic [2:0] s, input logic [17:0] d);
    cmd_req <= '{kind: k, mr_sel: s, mr_data: d};
    @(posedge sys_clk);
    cmd_req.kind <= CMD_DESELECT;
    @(posedge sys_clk);
  endtask

  task automatic chk_viol();
    bus(1'b0, `OFS_VIOL, 32'h0);
    `CHK(rd & 32'hFF, exp_viol)
    bus(1'b1, `OFS_VIOL, 32'hFF);
    exp_viol = 32'h0;
  endtask

  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 20000) begin
      err_count++;
      stop_test();
    end
  end

  initial begin
    reset_n <= 1'b0;
    idle(10);
    reset_n <= 1'b1;
    idle(1);
    `CHK(loop_enabled, 1'b1)
    `CHK(fb_oe_n, 16'hFFFF)
    for (int i = 0; i < 8; i++) begin
      bus(1'b0, 6'(4 * i), 32'h0);
      `CHK(rd, {16'h0, dflt[i]})
    end
    bus(1'b0, `OFS_STATUS, 32'h0);
    `CHK(rd, 32'h2)
    rng = xs(rng);
    bus(1'b1, 6'h3C, rng);
    bus(1'b0, 6'h3C, 32'h0);
    `CHK(rd, 32'h0)
    for (int i = 1; i < 8; i++) begin
      bus(1'b1, 6'(4 * i), (i == 6) ? 32'hC : (i == 3) ? 32'h18 : 32'h4);
    end
    send(CMD_MODE_SET, 3'h1, 18'h0);
    idle(6);
    `CHK(loop_enabled, 1'b0)
    send(CMD_MODE_SET, 3'h1, 18'h1);
    send(CMD_MODE_SET, 3'h0, 18'h100);
    idle(4);
    send(CMD_READ, 3'h0, 18'h0);
    `CHK(loop_enabled, 1'b1)
    exp_viol = 32'h0A;
    chk_viol();
    idle(12);
    send(CMD_SR_ENTRY, 3'h0, 18'h0);
    send(CMD_ACTIVATE, 3'h0, 18'h0);
    `CHK(in_self_refresh, 1'b1)
    send(CMD_SR_EXIT, 3'h0, 18'h0);
    // Fast delay over, full exit delay still running: limited mode write is legal
    idle(3);
    send(CMD_MODE_SET, 3'h2, 18'h0);
    chk_viol();
    send(CMD_ACTIVATE, 3'h0, 18'h0);
    refcnt++;
    exp_viol = 32'h04;
    `CHK(in_self_refresh, 1'b0)
    idle(6);
    bus(1'b0, `OFS_STATUS, 32'h0);
    `CHK(rd[31:16], 16'(refcnt))
    `CHK(rd[4], 1'b1)
    chk_viol();
    bus(1'b1, `OFS_CTRL, 32'h1);
    send(CMD_SR_ENTRY, 3'h0, 18'h0);
    idle(2);
    send(CMD_SR_EXIT, 3'h0, 18'h0);
    idle(8);
    bus(1'b0, `OFS_STATUS, 32'h0);
    `CHK(rd[31:16], 16'(refcnt))
    `CHK(rd[4], 1'b1)
    exp_viol = 32'h40;
    chk_viol();
    send(CMD_MODE_SET, 3'h1, 18'h1081);
    idle(6);
    `CHK(strobe_term_on, 1'b1)
    `CHK(fb_oe_n, 16'hFFFF)
    send(CMD_MODE_SET, 3'h1, 18'h0081);
    idle(6);
    `CHK(fb_oe_n, 16'h0000)
    for (int i = 0; i < 4; i++) begin
      rng = xs(rng);
      ck_level <= rng[0];
      strobe_req <= 2'(1 << (i % 2));
      exp_fb[(i % 2) * 8 +: 8] = {8{rng[0]}};
      idle(1);
      strobe_req <= 2'h0;
      idle(4);
      `CHK(fb_data, exp_fb)
    end
    send(CMD_ACTIVATE, 3'h0, 18'h0);
    send(CMD_MODE_SET, 3'h1, 18'h1);
    idle(6);
    `CHK(strobe_term_on, 1'b0)
    `CHK(fb_oe_n, 16'hFFFF)
    exp_viol = 32'h20;
    chk_viol();
    // Early calibration with clock enable dropped inside the mode-set wait
    send(CMD_MODE_SET, 3'h2, 18'h0);
    cke_req <= 1'b0;
    send(CMD_LONG_CALIB, 3'h0, 18'h0);
    cke_req <= 1'b1;
    send(CMD_PRECHARGE, 3'h0, 18'h0);
    exp_viol = 32'h91;
    chk_viol();
    send(CMD_SHORT_CALIB, 3'h0, 18'h0);
    send(CMD_WRITE, 3'h0, 18'h0);
    exp_viol = 32'h10;
    chk_viol();
    // A refresh after exit clears the need and lets self refresh be entered cleanly
    send(CMD_REFRESH, 3'h0, 18'h0);
    refcnt++;
    send(CMD_SR_ENTRY, 3'h0, 18'h0);
    idle(2);
    bus(1'b0, `OFS_STATUS, 32'h0);
    `CHK(rd, {16'(refcnt), 16'h0003})
    exp_viol = 32'h0;
    chk_viol();
    stop_test();
  end
endmodule
